// ---- aiofc_pkg.sv ----
/*
 Constants, field layout, reset values and timing counts for the auxiliary
 line function control block.
 Assumes a 100 MHz core clock and 16-bit serial words made of one direction
 bit, a 7-bit byte address and one data byte.
*/
// Function
// - each line carries exactly one function
// - priority: data ready, sync input, general use
// - function write takes effect after 20 ms
// - pulse mode rate is clock times scale
// - direct sync disables the internal sample clock
// - bit 7 enables the sync clock input
// - bit 6 picks rising or falling edge
// - bits 5:4 pick the sync line
// - bits 3:0 enable, polarity, line of ready
// - ready stops toggling while controller busy
// - function register resets to ready on line two
// - general register drives only unclaimed lines
// - bits 3:0 set line directions
// - bits 7:4 read inputs, drive outputs
// - level bits follow pins, rest reset zero
// - config bit 7 enables linear g compensation
// - config bit 6 enables percussion alignment
// - pulse mode ready waits for two edges
package aiofc_pkg;
   // ==========================================================
   // lines and serial word layout
   localparam int NUM_LINES = 4;
   localparam int LINE_SEL_W = 2;
   localparam logic [NUM_LINES-1:0] LINE_ONE = 4'h1;
   localparam int WORD_W = 16;
   localparam int WR_BIT = 15;
   localparam int ADDR_LSB = 8;
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   // ==========================================================
   // register map
   localparam logic [ADDR_W-1:0] ADDR_PAGE = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_FN_LO = 7'h06;
   localparam logic [ADDR_W-1:0] ADDR_FN_HI = 7'h07;
   localparam logic [ADDR_W-1:0] ADDR_GP_LO = 7'h08;
   localparam logic [ADDR_W-1:0] ADDR_CF_LO = 7'h0A;
   localparam logic [BYTE_W-1:0] REG_PAGE = 8'h03;
   localparam logic [BYTE_W-1:0] PAGE_RESET = 8'h00;
   localparam logic [WORD_W-1:0] FN_RESET = 16'h000D;
   localparam logic [WORD_W-1:0] FN_USED = 16'h01FF;
   localparam logic [WORD_W-1:0] CFG_RESET = 16'h00C0;
   localparam logic [WORD_W-1:0] CFG_USED = 16'h00C0;
   localparam logic [NUM_LINES-1:0] GP_DIR_RESET = 4'h0;
   localparam logic [NUM_LINES-1:0] GP_LVL_RESET = 4'h0;

   // ==========================================================
   // field positions
   localparam int FN_PPS_BIT = 8;
   localparam int FN_SYNC_EN_BIT = 7;
   localparam int FN_SYNC_POL_BIT = 6;
   localparam int FN_SYNC_SEL_LSB = 4;
   localparam int FN_DR_EN_BIT = 3;
   localparam int FN_DR_POL_BIT = 2;
   localparam int FN_DR_SEL_LSB = 0;
   localparam int GP_DIR_LSB = 0;
   localparam int GP_LVL_LSB = 4;
   localparam int CFG_LG_BIT = 7;
   localparam int CFG_POP_BIT = 6;

   // ==========================================================
   // timing
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int FN_DELAY_MS = 20;
   localparam int FN_DELAY_CYC = CLK_FREQ_HZ / 1000 * FN_DELAY_MS;
   localparam int PPS_MIN_HZ = 1;
   localparam int PPS_MAX_HZ = 128;
   localparam int PPS_MAX_PERIOD_CYC = CLK_FREQ_HZ / PPS_MIN_HZ;
   localparam int PPS_MIN_PERIOD_CYC = (CLK_FREQ_HZ + PPS_MAX_HZ - 1) / PPS_MAX_HZ;

   typedef enum logic [1:0] {
      FN_IDLE = 2'b01,
      FN_WAIT = 2'b10
   } aiofc_fn_state_t;
endpackage

// ---- aiofc_link_if.sv ----
/*
 Carrier between the serial link front end and the register core.
 Assumes wrWord is stable whenever wordValid is high, and rdWord changes
 only between frames.
*/
`timescale 1ns/1ns
interface aiofc_link_if;
   import aiofc_pkg::*;
   logic wordValid;
   logic [WORD_W-1:0] wrWord;
   logic [WORD_W-1:0] rdWord;
   modport link (output wordValid, output wrWord, input rdWord);
   modport core (input wordValid, input wrWord, output rdWord);
endinterface

// ---- aiofc_spi_link.sv ----
/*
 Serial front end on the link clock: collects one 16-bit word per frame and
 shifts out the word prepared by the core during the gap before the frame.
 Assumes clock idles high, input sampled on rising edges, one word per
 chip select low period.
*/
`timescale 1ns/1ns
module aiofc_spi_link import aiofc_pkg::*; (
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   output logic miso,
   aiofc_link_if.link lnk
);
   typedef struct packed {
      logic [3:0] bitCnt;
      logic [WORD_W-2:0] shIn;
      logic wordValid;
   } aiofc_frame_t;

   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam logic [3:0] FIRST_BIT = 4'h0;

   aiofc_frame_t frQ;
   aiofc_frame_t frD;
   logic [WORD_W-1:0] wrWordQ;
   logic [WORD_W-1:0] outQ;

   // ==========================================================
   // input shifter
   always_comb begin
      frD = frQ;
      frD.shIn = {frQ.shIn[WORD_W-3:0], mosi};
      frD.bitCnt = frQ.bitCnt + 4'h1;
      if (frQ.bitCnt == LAST_BIT) begin
         frD.wordValid = 1'b1;
      end
   end

   // frame state ends with the frame itself; the clock may stop after it
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         frQ <= '0;
      end else begin
         frQ <= frD;
      end
   end

   // word kept after the frame so the core can take it at leisure
   always_ff @(posedge sclk) begin
      if (!csN && frQ.bitCnt == LAST_BIT) begin
         wrWordQ <= {frQ.shIn, mosi};
      end
   end

   // first falling edge loads the answer, later ones shift it
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         outQ <= '0;
      end else if (frQ.bitCnt == FIRST_BIT && !frQ.wordValid) begin
         outQ <= lnk.rdWord;
      end else begin
         outQ <= {outQ[WORD_W-2:0], 1'b0};
      end
   end

   assign miso = outQ[WORD_W-1];
   assign lnk.wordValid = frQ.wordValid;
   assign lnk.wrWord = wrWordQ;
endmodule

// ---- aiofc_top.sv ----
/*
 Auxiliary line function control: page 3 registers, per-line function
 selection, data ready drive, external sync clock handling and pins.
 Assumes the host leaves at least 60 ns between the 16th clock and chip
 select rising, and at least 60 ns with chip select high between frames.
*/
`timescale 1ns/1ns
module aiofc_top import aiofc_pkg::*; #(
   parameter int FN_DELAY_CYCLES = FN_DELAY_CYC,
   parameter int PPS_MIN_PERIOD = PPS_MIN_PERIOD_CYC,
   parameter int PPS_MAX_PERIOD = PPS_MAX_PERIOD_CYC,
   parameter int FN_CNT_W = 21,
   parameter int PER_W = 27
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   output logic miso,
   input wire logic [NUM_LINES-1:0] auxLineIn,
   output logic [NUM_LINES-1:0] auxLineOut,
   output logic [NUM_LINES-1:0] auxLineOeN,
   input wire logic dataReadyRaw,
   input wire logic controllerBusy,
   input wire logic [WORD_W-1:0] externalClockScaleFactor,
   output logic sampleTick,
   output logic internalClockEnable,
   output logic pulsePerSecondMode,
   output logic linearGCompEnable,
   output logic percussionAlignEnable
);
   localparam int ACC_W = PER_W + 1;

   typedef struct packed {
      logic wvS1;
      logic wvS2;
      logic wvS3;
      logic [NUM_LINES-1:0] lineS1;
      logic [NUM_LINES-1:0] lineS2;
      logic [BYTE_W-1:0] pageQ;
      logic [WORD_W-1:0] fnQ;
      logic [WORD_W-1:0] fnPendQ;
      aiofc_fn_state_t fnSt;
      logic [FN_CNT_W-1:0] fnCntQ;
      logic [NUM_LINES-1:0] gpDirQ;
      logic [NUM_LINES-1:0] gpLvlQ;
      logic [WORD_W-1:0] cfgQ;
      logic [WORD_W-1:0] rdWordQ;
      logic syncPrevQ;
      logic seenEdgeQ;
      logic lockQ;
      logic [PER_W-1:0] perCntQ;
      logic [PER_W-1:0] periodQ;
      logic [ACC_W-1:0] accQ;
      logic tickQ;
      logic drOutQ;
   } aiofc_state_t;

   aiofc_state_t q;
   aiofc_state_t d;
   aiofc_link_if lnk();

   // ==========================================================
   // decode helpers
   function automatic logic [NUM_LINES-1:0] lineMask(input logic en, input logic [LINE_SEL_W-1:0] sel);
      lineMask = en ? (LINE_ONE << sel) : '0;
   endfunction

   // drop unused bits, then let data ready win a shared line
   function automatic logic [WORD_W-1:0] resolveFn(input logic [WORD_W-1:0] v);
      logic [WORD_W-1:0] r;
      r = v & FN_USED;
      if (r[FN_DR_EN_BIT] && r[FN_SYNC_EN_BIT] &&
          r[FN_DR_SEL_LSB +: LINE_SEL_W] == r[FN_SYNC_SEL_LSB +: LINE_SEL_W]) begin
         r[FN_SYNC_EN_BIT] = 1'b0;
      end
      return r;
   endfunction

   aiofc_spi_link u_link (
      .sclk(sclk),
      .csN(csN),
      .mosi(mosi),
      .miso(miso),
      .lnk(lnk.link)
   );

   // ==========================================================
   // word decode and field views
   logic wordEv;
   logic isWr;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] evenAddr;
   logic [BYTE_W-1:0] dat;
   logic [NUM_LINES-1:0] datDir;
   logic drEn;
   logic drPol;
   logic [LINE_SEL_W-1:0] drSel;
   logic syncEn;
   logic syncPol;
   logic ppsMode;
   logic [LINE_SEL_W-1:0] syncSel;
   logic [NUM_LINES-1:0] drMask;
   logic [NUM_LINES-1:0] syncMask;
   logic syncLvl;
   logic syncEdge;
   logic ppsActive;
   logic fnApply;
   logic drActive;
   logic [ACC_W-1:0] accSum;
   logic [WORD_W-1:0] readValue;

   // word event taken on the rise of the twice-synchronised valid level
   assign wordEv = q.wvS2 && !q.wvS3;
   assign isWr = lnk.wrWord[WR_BIT];
   assign addr = lnk.wrWord[ADDR_LSB +: ADDR_W];
   assign evenAddr = {addr[ADDR_W-1:1], 1'b0};
   assign dat = lnk.wrWord[BYTE_W-1:0];
   assign datDir = dat[GP_DIR_LSB +: NUM_LINES];
   assign drEn = q.fnQ[FN_DR_EN_BIT];
   assign drPol = q.fnQ[FN_DR_POL_BIT];
   assign drSel = q.fnQ[FN_DR_SEL_LSB +: LINE_SEL_W];
   assign syncEn = q.fnQ[FN_SYNC_EN_BIT];
   assign syncPol = q.fnQ[FN_SYNC_POL_BIT];
   assign ppsMode = q.fnQ[FN_PPS_BIT];
   assign syncSel = q.fnQ[FN_SYNC_SEL_LSB +: LINE_SEL_W];
   assign drMask = lineMask(drEn, drSel);
   assign syncMask = lineMask(syncEn, syncSel);
   assign syncLvl = q.lineS2[syncSel];
   // edge choice by polarity bit
   assign syncEdge = syncEn && (syncPol ? (syncLvl && !q.syncPrevQ) : (!syncLvl && q.syncPrevQ));
   assign ppsActive = syncEn && ppsMode;
   assign fnApply = (q.fnSt == FN_WAIT) && (q.fnCntQ == FN_CNT_W'(FN_DELAY_CYCLES - 1));
   // ready is held inactive while busy and, in pulse mode, until locked
   assign drActive = dataReadyRaw && !controllerBusy && (!ppsActive || q.lockQ);
   assign accSum = q.accQ + ACC_W'(externalClockScaleFactor);

   // readback mux; level bits come from the twice-synchronised pins
   always_comb begin
      if (evenAddr == ADDR_PAGE) begin
         readValue = {BYTE_ZERO, q.pageQ};
      end else if (q.pageQ != REG_PAGE) begin
         readValue = '0;
      end else if (evenAddr == ADDR_FN_LO) begin
         readValue = q.fnQ;
      end else if (evenAddr == ADDR_GP_LO) begin
         readValue = {BYTE_ZERO, q.lineS2, q.gpDirQ};
      end else if (evenAddr == ADDR_CF_LO) begin
         readValue = q.cfgQ;
      end else begin
         readValue = '0;
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      logic [WORD_W-1:0] stage;
      stage = '0;
      d = q;
      d.wvS1 = lnk.wordValid;
      d.wvS2 = q.wvS1;
      d.wvS3 = q.wvS2;
      d.lineS1 = auxLineIn;
      d.lineS2 = q.lineS1;
      d.syncPrevQ = syncLvl;
      d.tickQ = 1'b0;

      // deferred function update; old value stays visible meanwhile
      case (q.fnSt)
         FN_IDLE: begin
            d.fnCntQ = '0;
         end
         FN_WAIT: begin
            if (fnApply) begin
               d.fnQ = resolveFn(q.fnPendQ);
               d.fnSt = FN_IDLE;
            end else begin
               d.fnCntQ = q.fnCntQ + FN_CNT_W'(1);
            end
         end
         default: begin
            d.fnSt = FN_IDLE;
         end
      endcase

      // register writes; a new byte restarts the wait
      if (wordEv && isWr) begin
         if (addr == ADDR_PAGE) begin
            d.pageQ = dat;
         end else if (q.pageQ == REG_PAGE) begin
            if (addr == ADDR_FN_LO || addr == ADDR_FN_HI) begin
               stage = (q.fnSt == FN_WAIT) ? q.fnPendQ : q.fnQ;
               if (addr == ADDR_FN_LO) begin
                  stage[BYTE_W-1:0] = dat;
               end else begin
                  stage[WORD_W-1:BYTE_W] = dat;
               end
               d.fnPendQ = stage;
               d.fnSt = FN_WAIT;
               d.fnCntQ = '0;
            end else if (addr == ADDR_GP_LO) begin
               d.gpDirQ = datDir;
               d.gpLvlQ = dat[GP_LVL_LSB +: NUM_LINES];
            end else if (addr == ADDR_CF_LO) begin
               d.cfgQ = {BYTE_ZERO, dat} & CFG_USED;
            end
         end
      end else if (wordEv) begin
         d.rdWordQ = readValue;
      end

      // period measurement; saturates so a dead source never wraps to valid
      if (q.perCntQ != '1) begin
         d.perCntQ = q.perCntQ + PER_W'(1);
      end
      if (!ppsActive) begin
         d.seenEdgeQ = 1'b0;
         d.lockQ = 1'b0;
         d.accQ = '0;
      end else begin
         if (syncEdge) begin
            d.perCntQ = PER_W'(1);
            d.seenEdgeQ = 1'b1;
            if (q.seenEdgeQ && q.perCntQ >= PER_W'(PPS_MIN_PERIOD) && q.perCntQ <= PER_W'(PPS_MAX_PERIOD)) begin
               d.lockQ = 1'b1;
               d.periodQ = q.perCntQ;
            end else if (q.seenEdgeQ) begin
               d.lockQ = 1'b0;
            end
         end
         // scale ticks per measured period; one tick a cycle at most
         if (q.lockQ) begin
            if (accSum >= {1'b0, q.periodQ}) begin
               d.accQ = accSum - {1'b0, q.periodQ};
               d.tickQ = 1'b1;
            end else begin
               d.accQ = accSum;
            end
         end
      end
      if (syncEn && !ppsMode) begin
         d.tickQ = syncEdge;
      end
      d.drOutQ = drPol ? drActive : !drActive;
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q <= '0;
         q.pageQ <= PAGE_RESET;
         q.fnQ <= FN_RESET;
         q.fnPendQ <= FN_RESET;
         q.fnSt <= FN_IDLE;
         q.gpDirQ <= GP_DIR_RESET;
         q.gpLvlQ <= GP_LVL_RESET;
         q.cfgQ <= CFG_RESET;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // pins and outputs
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
      // claimed lines ignore the general register
      assign auxLineOut[i] = drMask[i] ? q.drOutQ : q.gpLvlQ[i];
      assign auxLineOeN[i] = drMask[i] ? 1'b0 : (syncMask[i] ? 1'b1 : !q.gpDirQ[i]);
   end

   assign lnk.rdWord = q.rdWordQ;
   assign sampleTick = q.tickQ;
   assign internalClockEnable = !(syncEn && !ppsMode);
   assign pulsePerSecondMode = ppsMode;
   assign linearGCompEnable = q.cfgQ[CFG_LG_BIT];
   assign percussionAlignEnable = q.cfgQ[CFG_POP_BIT];

   // ==========================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence sFnWrite;
      wordEv && isWr && q.pageQ == REG_PAGE && (addr == ADDR_FN_LO || addr == ADDR_FN_HI);
   endsequence
   sequence sFnHeld;
      q.fnSt == FN_WAIT && $stable(q.fnQ);
   endsequence
   sequence sGpWrite;
      wordEv && isWr && q.pageQ == REG_PAGE && addr == ADDR_GP_LO;
   endsequence
   sequence sGpRead;
      wordEv && !isWr && q.pageQ == REG_PAGE && evenAddr == ADDR_GP_LO;
   endsequence

   AST_FN_DEFERRED: assert property (sFnWrite ##0 !fnApply |=> sFnHeld)
      else $error("function register changed without waiting");
   AST_FN_ONLY_ON_APPLY: assert property ($changed(q.fnQ) |-> $past(fnApply))
      else $error("function register changed before the delay ended");
   AST_FN_RESET_VALUE: assert property ($rose(rst_n) |-> q.fnQ == FN_RESET && auxLineOeN[1] == 1'b0)
      else $error("function register reset value wrong");
   AST_ONE_FUNCTION: assert property ((drMask & syncMask) == '0)
      else $error("line carries two functions");
   AST_UNUSED_ZERO: assert property (((q.fnQ & ~FN_USED) == '0) && ((q.cfgQ & ~CFG_USED) == '0))
      else $error("unused bits not zero");
   AST_DR_BUSY_STILL: assert property (controllerBusy |=> q.drOutQ == !$past(drPol))
      else $error("ready toggled while busy");
   AST_PPS_WAIT_LOCK: assert property (ppsActive && !q.lockQ |=> q.drOutQ == !$past(drPol))
      else $error("ready toggled before pulse lock");
   AST_TICK_SOURCE: assert property (q.tickQ |-> $past(syncEn) && ($past(ppsMode) ? $past(q.lockQ) : $past(syncEdge)))
      else $error("sample tick without valid source");
   AST_EDGE_POLARITY: assert property (syncEdge |-> syncLvl == syncPol)
      else $error("sync edge of wrong polarity");
   AST_DR_ON_LINE: assert property (drEn |-> auxLineOeN[drSel] == 1'b0 && auxLineOut[drSel] == q.drOutQ)
      else $error("ready not driven on its line");
   AST_SYNC_LINE_INPUT: assert property (syncEn |-> auxLineOeN[syncSel])
      else $error("sync line is driven");
   AST_GP_DIR_WRITE: assert property (sGpWrite |=> q.gpDirQ == $past(datDir))
      else $error("direction bits not written");
   AST_GP_READ_LEVEL: assert property (sGpRead |=> q.rdWordQ[GP_LVL_LSB +: NUM_LINES] == $past(q.lineS2))
      else $error("level bits do not follow pins");
   AST_CFG_RESET: assert property ($rose(rst_n) |-> linearGCompEnable && percussionAlignEnable)
      else $error("config reset value wrong");
endmodule

// ---- aiofc_host_model.sv ----
/*
 Host processor model for the auxiliary line block: drives serial frames
 of one 16-bit word each and reports the word shifted back on miso.
 Assumes the device samples on rising sclk and shifts out on falling sclk.
*/
`timescale 1ns/1ns
module aiofc_host_model import aiofc_pkg::*; (
   output logic sclk,
   output logic csN,
   output logic mosi,
   input wire logic miso,
   output logic [WORD_W-1:0] ansWord,
   output logic ansValid
);
   // ==========================================================
   // idle levels: clock parked high outside frames
   initial begin
      sclk = 1'h1;
      csN = 1'h1;
      mosi = 1'h0;
      ansWord = 16'h0000;
      ansValid = 1'h0;
   end

   // ==========================================================
   // one frame, msb first, mosi moves on falling edges
   task automatic xfer(input logic [WORD_W-1:0] w, input logic keep);
      logic [WORD_W-1:0] r;
      r = 16'h0000;
      csN = 1'h0;
      #15;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         sclk = 1'h0;
         mosi = w[i];
         #15;
         sclk = 1'h1;
         r[i] = miso;
         #15;
      end
      #75; // hold select past the core's pickup
      csN = 1'h1;
      mosi = ~mosi; // released line never shows the stale bit
      if (keep) begin
         ansWord = r;
         ansValid = 1'h1;
         #10;
         ansValid = 1'h0;
      end
      #90; // frame gap for the word crossing
   endtask
endmodule

// ---- aiofc_bench.sv ----
/*
 Self-checking bench for the auxiliary line function control block.
 Assumes the host model drives the serial port and the bench plays the
 outside world on the four lines, the ready source and the busy flag.
*/
`timescale 1ns/1ns
module aiofc_bench import aiofc_pkg::*;;
   localparam int FND = 200;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic sclk, csN, mosi, miso, ansValid, sampleTick;
   logic internalClockEnable, pulsePerSecondMode, linearGCompEnable, percussionAlignEnable;
   logic [NUM_LINES-1:0] auxLineIn, auxLineOut, auxLineOeN;
   logic [NUM_LINES-1:0] extDrv = 4'h0;
   logic dataReadyRaw = 1'h0;
   logic controllerBusy = 1'h0;
   logic [WORD_W-1:0] scale = 16'h0004;
   logic [WORD_W-1:0] ansWord;
   logic [WORD_W-1:0] expQ[$];
   int err_total = 0;
   int checked = 0;
   int ticks = 0;
   int seed = 18;
   int n;

   // ==========================================================
   // clock, wire resolution, tick count
   always #5 clock = ~clock;
   assign auxLineIn = (auxLineOeN & extDrv) | (~auxLineOeN & auxLineOut);
   always @(posedge clock) if (sampleTick === 1'h1) ticks <= ticks + 1;

   aiofc_host_model aiofc_host_model_i (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
      .ansWord(ansWord), .ansValid(ansValid));

   // short counts keep the run brief
   aiofc_top #(.FN_DELAY_CYCLES(FND), .PPS_MIN_PERIOD(20), .PPS_MAX_PERIOD(2000)) aiofc_top_i (
      .clock(clock), .rst_n(rst_n), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
      .auxLineIn(auxLineIn), .auxLineOut(auxLineOut), .auxLineOeN(auxLineOeN),
      .dataReadyRaw(dataReadyRaw), .controllerBusy(controllerBusy),
      .externalClockScaleFactor(scale), .sampleTick(sampleTick),
      .internalClockEnable(internalClockEnable), .pulsePerSecondMode(pulsePerSecondMode),
      .linearGCompEnable(linearGCompEnable), .percussionAlignEnable(percussionAlignEnable));

   // ==========================================================
   // tasks
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task give_verdict;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // frames start 3 ns after an edge, so never on a core edge
   task automatic wr(input logic [15:0] w);
      @(posedge clock);
      #3;
      aiofc_host_model_i.xfer(w, 1'h0);
   endtask

   // answer comes back in the frame after the request
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      expQ.push_back(e);
      wr({1'h0, a, BYTE_ZERO});
      @(posedge clock);
      #3;
      aiofc_host_model_i.xfer(16'h0000, 1'h1);
   endtask

   task settle;
      repeat (FND + 10) @(posedge clock);
   endtask

   task automatic edge_tick(input int ln, input logic v, input int e);
      int m;
      m = ticks;
      @(posedge clock);
      extDrv[ln] <= v;
      repeat (10) @(posedge clock);
      check("ticks", 16'(ticks - m), 16'(e));
   endtask

   // edges every half cycles, kept inside the accepted period span
   task automatic toggle(input int ln, input int half, input int cnt);
      repeat (cnt) begin
         @(posedge clock);
         extDrv[ln] <= ~extDrv[ln];
         repeat (half - 1) @(posedge clock);
      end
   endtask

   // ==========================================================
   // answer watcher: oldest note against each answer
   always @(posedge ansValid) begin
      if (expQ.size() > 0) check("readback", ansWord, expQ.pop_front());
      else check("unexpected answer", 16'h0001, 16'h0000);
   end

   // watchdog
   initial begin
      #400000;
      err_total++;
      give_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'h1;
      repeat (2) @(posedge clock);
      check("oeN", 16'(auxLineOeN), 16'h000D);
      check("ready", 16'(auxLineOut[1]), 16'h0000);
      check("lin g", 16'({linearGCompEnable, percussionAlignEnable}), 16'h0003);
      wr(16'h8A00); // refused before page select
      wr(16'h8003);
      rd(ADDR_PAGE, 16'h0003);
      rd(ADDR_FN_LO, FN_RESET);
      rd(ADDR_CF_LO, CFG_RESET);
      rd(ADDR_GP_LO, 16'h0000);
      wr(16'h8A40);
      check("lin g", 16'({linearGCompEnable, percussionAlignEnable}), 16'h0001);
      rd(ADDR_CF_LO, 16'h0040);
      wr(16'h8AFF);
      wr(16'h8B55);
      rd(7'h0B, 16'h00C0);
      wr(16'h9A55);
      rd(7'h1A, 16'h0000);
      // ready moves to line three, negative
      @(posedge clock) dataReadyRaw <= 1'h1;
      wr(16'h860A);
      wr(16'h8700);
      rd(ADDR_FN_LO, FN_RESET);
      check("oeN wait", 16'(auxLineOeN), 16'h000D);
      settle();
      rd(ADDR_FN_LO, 16'h000A);
      check("oeN", 16'(auxLineOeN), 16'h000B);
      check("ready neg", 16'(auxLineOut[2]), 16'h0000);
      @(posedge clock) controllerBusy <= 1'h1;
      repeat (3) @(posedge clock);
      check("busy", 16'(auxLineOut[2]), 16'h0001);
      @(posedge clock) controllerBusy <= 1'h0;
      repeat (3) @(posedge clock);
      check("resume", 16'(auxLineOut[2]), 16'h0000);
      // general lines: one out at level one, three kept by ready, random inputs
      @(posedge clock) extDrv <= 4'($random(seed)) | 4'h8;
      wr(16'h8855);
      repeat (5) @(posedge clock);
      check("gp oeN", 16'(auxLineOeN), 16'h000A);
      check("gp out", 16'(auxLineOut[0]), 16'h0001);
      rd(ADDR_GP_LO, {8'h00, extDrv[3], 1'h0, extDrv[1], 1'h1, 4'h5});
      // direct sync, falling edge, line four
      wr(16'h86BD);
      wr(16'h8700);
      settle();
      check("int clk", 16'({internalClockEnable, pulsePerSecondMode}), 16'h0000);
      rd(ADDR_FN_LO, 16'h00BD);
      edge_tick(3, 1'h0, 1);
      edge_tick(3, 1'h1, 0);
      edge_tick(3, 1'h0, 1);
      // sync on ready's line loses
      wr(16'h869D);
      wr(16'h8700);
      settle();
      rd(ADDR_FN_LO, 16'h001D);
      check("int clk", 16'(internalClockEnable), 16'h0001);
      check("oeN", 16'(auxLineOeN), 16'h0008);
      check("gp three", 16'(auxLineOut[2]), 16'h0001);
      // pulse mode on line three, scale four
      @(posedge clock) extDrv[2] <= 1'h0;
      wr(16'h86ED);
      wr(16'h8701);
      settle();
      check("pps", 16'(pulsePerSecondMode), 16'h0001);
      rd(ADDR_FN_LO, 16'h01ED);
      check("no lock", 16'(auxLineOut[1]), 16'h0000);
      toggle(2, 150, 4);
      check("locked", 16'(auxLineOut[1]), 16'h0001);
      n = ticks;
      toggle(2, 150, 4);
      check("rate", 16'((ticks - n) >= 7 && (ticks - n) <= 9), 16'h0001);
      repeat (5) @(posedge clock);
      give_verdict();
   end
endmodule
